// file: hw/mbs_frame_handler.sv
// modbus slave frame handler: receive, check, exception reply, flags and registers
`timescale 1ns/1ps
module mbs_frame_handler
   import mbs_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYCLES_DEF,
   parameter int IDLE35_CYCLES = IDLE35_CYCLES_DEF
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ascii_mode,
   input wire logic [2:0] port_id,
   input wire logic [7:0] cfg_slave_number,
   input wire logic scan_end,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   input wire logic wr_en,
   input wire logic [2:0] wr_sel,
   input wire logic [15:0] wr_data,
   input wire logic [2:0] rd_sel,
   output logic [15:0] rd_data,
   output logic comm_error_flag,
   output logic comm_done_flag,
   output logic [15:0] comm_error_code,
   output logic req_ok,
   output logic req_bcast,
   output logic [7:0] req_fn,
   output logic [15:0] req_addr,
   output logic [15:0] req_qty
);
   mbs_rx_state_type rx_state_ff;
   mbs_tx_state_type tx_state_ff;
   logic [7:0] hdr_ff [0:5];
   logic [7:0] nbytes_ff, sum_ff;
   logic [15:0] crc_ff;
   logic [3:0] nib_ff;
   logic half_ff, cr_seen_ff, end_ff, chr_err_ff;
   logic [31:0] gap_ff, ms_cnt_ff;
   logic [15:0] ms_left_ff, tx_wait_ff;
   logic [15:0] slv_ff [0:NUM_PORTS-1];
   logic [7:0] tx_buf_ff [0:10];
   logic [3:0] tx_idx_ff, tx_len_ff;
   logic [1:0] pend_ff, flag_ff;
   logic [15:0] code_ff, rd_ff;
   logic tx_valid_ff, ok_ff, bc_ff;
   logic [7:0] tx_data_ff, fn_ff;
   logic [15:0] addr_ff, qty_ff;
   logic [7:0] c, act_slave, ev_code, rx_byte, lrc;
   logic [4:0] hv;
   logic [2:0] pidx;
   logic [15:0] addr, qty, tx_crc;
   logic fixed_fn, multi_fn, bits_fn, len_short, chk_ok, mine, ev_done, ev_err, ev_reply;
   logic tx_last;
   logic [1:0] evt;

   // ascii characters carry 7 data bits
   assign c = ascii_mode ? (rx_data & ASC_MASK) : rx_data;
   assign hv = mbs_hex_val(c);
   assign rx_byte = {nib_ff, hv[3:0]};

   // active slave number: register when in range, else the static one
   assign pidx = port_id - PORT_BASE;
   assign act_slave = (slv_ff[pidx] >= SLAVE_MIN && slv_ff[pidx] <= SLAVE_MAX) ?
                      slv_ff[pidx][7:0] : cfg_slave_number;

   // receive framing; a colon restarts, a gap closes an rtu frame
   always_ff @(posedge mclk) begin
      end_ff <= 1'b0;
      chr_err_ff <= 1'b0;
      if (!rst_n) begin
         rx_state_ff <= RX_HUNT;
         nbytes_ff <= 8'h00;
         sum_ff <= 8'h00;
         crc_ff <= CRC_INIT;
         nib_ff <= 4'h0;
         half_ff <= 1'b0;
         cr_seen_ff <= 1'b0;
         gap_ff <= 32'h0000_0000;
         for (int i = 0; i < 6; i++) hdr_ff[i] <= 8'h00;
      end else if (ascii_mode) begin
         if (rx_valid && c == CHR_COLON) begin
            rx_state_ff <= RX_BODY;
            nbytes_ff <= 8'h00;
            sum_ff <= 8'h00;
            half_ff <= 1'b0;
            cr_seen_ff <= 1'b0;
         end else if (rx_valid && rx_state_ff == RX_BODY) begin
            if (c == CHR_CR && !cr_seen_ff) begin
               cr_seen_ff <= 1'b1;
            end else if (c == CHR_LF && cr_seen_ff) begin
               end_ff <= 1'b1;
               rx_state_ff <= RX_HUNT;
            end else if (hv[4] && !cr_seen_ff) begin
               half_ff <= !half_ff;
               if (!half_ff) begin
                  nib_ff <= hv[3:0];
               end else begin
                  if (nbytes_ff < HDR_LEN) hdr_ff[nbytes_ff[2:0]] <= rx_byte;
                  sum_ff <= sum_ff + rx_byte;
                  if (nbytes_ff != 8'hFF) nbytes_ff <= nbytes_ff + 8'h01;
               end
            end else begin
               chr_err_ff <= 1'b1;
               rx_state_ff <= RX_HUNT;
            end
         end
      end else begin
         if (rx_valid) begin
            gap_ff <= 32'h0000_0000;
            // a character before the line was idle long enough starts no frame
            if (rx_state_ff == RX_BODY || gap_ff >= 32'(IDLE35_CYCLES - 1)) begin
               rx_state_ff <= RX_BODY;
               if (rx_state_ff == RX_HUNT) begin
                  hdr_ff[0] <= c;
                  nbytes_ff <= 8'h01;
                  crc_ff <= mbs_crc_step(CRC_INIT, c);
               end else begin
                  if (nbytes_ff < HDR_LEN) hdr_ff[nbytes_ff[2:0]] <= c;
                  if (nbytes_ff != 8'hFF) nbytes_ff <= nbytes_ff + 8'h01;
                  crc_ff <= mbs_crc_step(crc_ff, c);
               end
            end
         end else begin
            if (gap_ff != 32'hFFFF_FFFF) gap_ff <= gap_ff + 32'h0000_0001;
            if (rx_state_ff == RX_BODY && gap_ff == 32'(IDLE35_CYCLES - 1)) begin
               end_ff <= 1'b1;
               rx_state_ff <= RX_HUNT;
            end
         end
      end
   end

   // frame evaluation, taken in the cycle after the frame closes
   assign addr = {hdr_ff[2], hdr_ff[3]};
   assign qty = {hdr_ff[4], hdr_ff[5]};
   assign fixed_fn = hdr_ff[1] >= FC_RD_COILS && hdr_ff[1] <= FC_WR_REG;
   assign multi_fn = hdr_ff[1] == FC_WR_COILS || hdr_ff[1] == FC_WR_REGS;
   assign bits_fn = hdr_ff[1] < FC_RD_HOLD || hdr_ff[1] == FC_WR_COILS;
   assign len_short = (nbytes_ff < (ascii_mode ? MIN_LEN_ASC : MIN_LEN_RTU)) ||
                      (ascii_mode && half_ff);
   assign chk_ok = ascii_mode ? (sum_ff == 8'h00) : (crc_ff == 16'h0000);
   assign mine = hdr_ff[0] == act_slave || hdr_ff[0] == SLAVE_BCAST;

   always_comb begin
      ev_code = ERR_NONE;
      if (chr_err_ff) begin
         ev_code = ERR_CHAR;
      end else if (len_short) begin
         ev_code = ERR_LEN;
      end else if (!chk_ok) begin
         ev_code = ERR_BCC;
      end else if (!fixed_fn && !multi_fn) begin
         ev_code = ERR_FUNC;
      end else if (fixed_fn ? nbytes_ff != (ascii_mode ? FIX_LEN_ASC : FIX_LEN_RTU) :
                  nbytes_ff < (ascii_mode ? FIX_LEN_ASC : FIX_LEN_RTU) + MULTI_EXTRA) begin
         ev_code = ERR_LEN;
      end else if (hdr_ff[1] == FC_WR_COIL ? (qty != COIL_ON && qty != COIL_OFF) :
                  (hdr_ff[1] != FC_WR_REG &&
                  (qty == 16'h0000 || qty > (bits_fn ? BITS_MAX : WORDS_MAX)))) begin
         ev_code = ERR_QTY;
      end else if ({1'b0, addr} >= ADDR_SPAN || (hdr_ff[1] != FC_WR_COIL &&
                  hdr_ff[1] != FC_WR_REG && {1'b0, addr} + {1'b0, qty} > ADDR_SPAN)) begin
         ev_code = ERR_ADDR;
      end
   end

   // framing errors are reported even when the slave cannot be trusted
   assign ev_err = chr_err_ff || (end_ff && (ev_code >= ERR_CHAR || (mine && ev_code != ERR_NONE)));
   assign ev_reply = end_ff && mine && ev_code != ERR_NONE && ev_code < ERR_CHAR &&
                     hdr_ff[0] != SLAVE_BCAST && tx_state_ff == TX_IDLE;
   assign ev_done = ev_err && !ev_reply || (end_ff && mine && ev_code == ERR_NONE) || tx_last;
   assign evt = {ev_done, ev_err};

   // events ride a pending bit to the next scan, then show for one whole scan
   generate
      for (genvar g = 0; g < 2; g++) begin : g_flag
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               pend_ff[g] <= 1'b0;
               flag_ff[g] <= 1'b0;
            end else if (scan_end) begin
               flag_ff[g] <= pend_ff[g] | evt[g];
               pend_ff[g] <= 1'b0;
            end else if (evt[g]) begin
               pend_ff[g] <= 1'b1;
            end
         end
      end
   endgenerate

   // error code is stored in the cycle after the error, with the pending bit, not at the scan that shows the flags
   always_ff @(posedge mclk) begin
      if (!rst_n) code_ff <= 16'h0000;
      else if (ev_err) code_ff <= {8'h00, ev_code};
   end

   // accepted requests go to the application
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ok_ff <= 1'b0;
         bc_ff <= 1'b0;
         fn_ff <= 8'h00;
         addr_ff <= 16'h0000;
         qty_ff <= 16'h0000;
      end else begin
         ok_ff <= end_ff && mine && ev_code == ERR_NONE;
         if (end_ff && mine && ev_code == ERR_NONE) begin
            bc_ff <= hdr_ff[0] == SLAVE_BCAST;
            fn_ff <= hdr_ff[1];
            addr_ff <= addr;
            qty_ff <= qty;
         end
      end
   end

   // software registers; slave numbers have no reset so they survive it
   always_ff @(posedge mclk) begin
      if (!rst_n) tx_wait_ff <= TX_WAIT_RST;
      else if (wr_en && wr_sel == SEL_TX_WAIT) tx_wait_ff <= wr_data;
   end
   always_ff @(posedge mclk) begin
      if (wr_en && wr_sel >= SEL_PORT2 && wr_sel != SEL_ERR_CODE)
         slv_ff[wr_sel - SEL_PORT2] <= wr_data;
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) rd_ff <= 16'h0000;
      else if (rd_sel == SEL_TX_WAIT) rd_ff <= tx_wait_ff;
      else if (rd_sel == SEL_ERR_CODE) rd_ff <= code_ff;
      else rd_ff <= slv_ff[rd_sel - SEL_PORT2];
   end

   // exception reply contents and check codes
   assign lrc = 8'h00 - (hdr_ff[0] + (hdr_ff[1] | EXC_FLAG) + ev_code);
   assign tx_crc = mbs_crc_step(mbs_crc_step(mbs_crc_step(CRC_INIT, hdr_ff[0]),
                   hdr_ff[1] | EXC_FLAG), ev_code);
   assign tx_last = tx_state_ff == TX_SEND && tx_ready && tx_valid_ff && tx_idx_ff == tx_len_ff - 4'h1;

   // transmit: wait time first, then characters under tx_ready
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_state_ff <= TX_IDLE;
         tx_idx_ff <= 4'h0;
         tx_len_ff <= 4'h0;
         ms_cnt_ff <= 32'h0000_0000;
         ms_left_ff <= 16'h0000;
         tx_valid_ff <= 1'b0;
         tx_data_ff <= 8'h00;
         for (int i = 0; i < 11; i++) tx_buf_ff[i] <= 8'h00;
      end else begin
         case (tx_state_ff)
            TX_IDLE: begin
               if (ev_reply) begin
                  tx_state_ff <= TX_WAIT;
                  tx_idx_ff <= 4'h0;
                  ms_cnt_ff <= 32'h0000_0000;
                  // out-of-range wait values are clamped to the valid span
                  ms_left_ff <= tx_wait_ff < TX_WAIT_MIN ? TX_WAIT_MIN :
                                tx_wait_ff > TX_WAIT_MAX ? TX_WAIT_MAX : tx_wait_ff;
                  if (ascii_mode) begin
                     tx_len_ff <= TX_LEN_ASC;
                     tx_buf_ff[0] <= CHR_COLON;
                     tx_buf_ff[1] <= mbs_hex_chr(hdr_ff[0][7:4]);
                     tx_buf_ff[2] <= mbs_hex_chr(hdr_ff[0][3:0]);
                     tx_buf_ff[3] <= mbs_hex_chr(hdr_ff[1][7:4] | EXC_FLAG[7:4]);
                     tx_buf_ff[4] <= mbs_hex_chr(hdr_ff[1][3:0]);
                     tx_buf_ff[5] <= mbs_hex_chr(ev_code[7:4]);
                     tx_buf_ff[6] <= mbs_hex_chr(ev_code[3:0]);
                     tx_buf_ff[7] <= mbs_hex_chr(lrc[7:4]);
                     tx_buf_ff[8] <= mbs_hex_chr(lrc[3:0]);
                     tx_buf_ff[9] <= CHR_CR;
                     tx_buf_ff[10] <= CHR_LF;
                  end else begin
                     tx_len_ff <= TX_LEN_RTU;
                     tx_buf_ff[0] <= hdr_ff[0];
                     tx_buf_ff[1] <= hdr_ff[1] | EXC_FLAG;
                     tx_buf_ff[2] <= ev_code;
                     tx_buf_ff[3] <= tx_crc[7:0];
                     tx_buf_ff[4] <= tx_crc[15:8];
                  end
               end
            end
            TX_WAIT: begin
               if (ms_cnt_ff == 32'(MS_CYCLES - 1)) begin
                  ms_cnt_ff <= 32'h0000_0000;
                  ms_left_ff <= ms_left_ff - 16'h0001;
                  if (ms_left_ff == 16'h0001) begin
                     tx_state_ff <= TX_SEND;
                     tx_valid_ff <= 1'b1;
                     tx_data_ff <= tx_buf_ff[0];
                  end
               end else begin
                  ms_cnt_ff <= ms_cnt_ff + 32'h0000_0001;
               end
            end
            TX_SEND: begin
               if (tx_ready) begin
                  if (tx_last) begin
                     tx_state_ff <= TX_IDLE;
                     tx_valid_ff <= 1'b0;
                  end else begin
                     tx_idx_ff <= tx_idx_ff + 4'h1;
                     tx_data_ff <= tx_buf_ff[tx_idx_ff + 4'h1];
                  end
               end
            end
            default: tx_state_ff <= TX_IDLE;
         endcase
      end
   end

   assign tx_valid = tx_valid_ff;
   assign tx_data = tx_data_ff;
   assign rd_data = rd_ff;
   assign comm_error_flag = flag_ff[0];
   assign comm_done_flag = flag_ff[1];
   assign comm_error_code = code_ff;
   assign req_ok = ok_ff;
   assign req_bcast = bc_ff;
   assign req_fn = fn_ff;
   assign req_addr = addr_ff;
   assign req_qty = qty_ff;

   // checks on the design's own outputs and internal state
   err_code_a: assert property (
      @(posedge mclk) disable iff (!rst_n) ev_err |=> comm_error_code == {8'h00, $past(ev_code)})
      else $error("error code not stored with the error");
   err_scan_a: assert property (
      @(posedge mclk) disable iff (!rst_n) scan_end && (ev_err || pend_ff[0]) |=> comm_error_flag)
      else $error("error flag missed the next scan");
   done_scan_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      comm_done_flag && scan_end && !pend_ff[1] && !evt[1] |=> !comm_done_flag)
      else $error("completion flag held past one scan");
   done_err_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ev_err && !ev_reply |=> pend_ff[1] || comm_done_flag)
      else $error("error without completion");
   colon_reset_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      ascii_mode && rx_valid && c == CHR_COLON |=> nbytes_ff == 8'h00 && rx_state_ff == RX_BODY)
      else $error("colon did not restart the frame");
   bcast_quiet_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      end_ff && hdr_ff[0] == SLAVE_BCAST && tx_state_ff == TX_IDLE |=> tx_state_ff == TX_IDLE)
      else $error("reply started for broadcast");
   wait_hold_a: assert property (
      @(posedge mclk) disable iff (!rst_n) tx_state_ff == TX_WAIT && ms_left_ff > 16'h0001 |-> !tx_valid)
      else $error("sent before the wait time elapsed");
   exc_fn_a: assert property (
      @(posedge mclk) disable iff (!rst_n) tx_valid && !ascii_mode && tx_idx_ff == 4'h1 |-> tx_data[7])
      else $error("exception function code lacks 80h");
   slave_fall_a: assert property (
      @(posedge mclk) disable iff (!rst_n) slv_ff[pidx] > SLAVE_MAX |-> act_slave == cfg_slave_number)
      else $error("out of range slave register used");
   slave_now_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      wr_en && wr_sel == pidx + SEL_PORT2 && wr_data >= SLAVE_MIN && wr_data <= SLAVE_MAX
      ##1 $stable(port_id) |-> act_slave == $past(wr_data[7:0]))
      else $error("new slave number not applied at once");
   rtu_gap_a: assert property (
      @(posedge mclk) disable iff (!rst_n) !ascii_mode && rx_state_ff == RX_HUNT && rx_valid &&
      gap_ff < 32'(IDLE35_CYCLES - 1) |=> rx_state_ff == RX_HUNT)
      else $error("rtu frame started without idle gap");
endmodule

// file: hw/mbs_pkg.sv
// constants, types and helper functions for the modbus slave frame handler
package mbs_pkg;
   localparam int CLK_HZ = 125_000_000;          // mclk rate
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
   localparam int CHAR_BITS = 11;                // start, 8 data, parity, stop
   localparam int BAUD_DEF = 9600;
   localparam int IDLE_TENTHS = 35;              // 3.5 characters, in tenths
   // least time, rounded up; 64-bit because the product passes 2^31
   localparam longint IDLE35_NUM = longint'(IDLE_TENTHS) * CHAR_BITS * CLK_HZ;
   localparam longint IDLE35_DEN = longint'(10) * BAUD_DEF;
   localparam int IDLE35_CYCLES_DEF = int'((IDLE35_NUM + IDLE35_DEN - 1) / IDLE35_DEN);
   // register selects
   localparam logic [2:0] SEL_TX_WAIT = 3'h0;
   localparam logic [2:0] SEL_PORT2 = 3'h1;      // ports 2..7 at 1..6
   localparam logic [2:0] SEL_ERR_CODE = 3'h7;
   localparam logic [2:0] PORT_BASE = 3'h2;
   localparam int NUM_PORTS = 6;
   // register values
   localparam logic [15:0] TX_WAIT_RST = 16'h0005;
   localparam logic [15:0] TX_WAIT_MIN = 16'h0001;
   localparam logic [15:0] TX_WAIT_MAX = 16'h1388;
   localparam logic [15:0] SLAVE_MIN = 16'h0001;
   localparam logic [15:0] SLAVE_MAX = 16'h00F7;
   localparam logic [7:0] SLAVE_BCAST = 8'h00;
   // error codes
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_FUNC = 8'h01;
   localparam logic [7:0] ERR_ADDR = 8'h02;
   localparam logic [7:0] ERR_QTY = 8'h03;
   localparam logic [7:0] ERR_CHAR = 8'h11;
   localparam logic [7:0] ERR_LEN = 8'h12;
   localparam logic [7:0] ERR_BCC = 8'h13;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   // function codes and limits
   localparam logic [7:0] FC_RD_COILS = 8'h01;
   localparam logic [7:0] FC_RD_HOLD = 8'h03;
   localparam logic [7:0] FC_RD_INREG = 8'h04;
   localparam logic [7:0] FC_WR_COIL = 8'h05;
   localparam logic [7:0] FC_WR_REG = 8'h06;
   localparam logic [7:0] FC_WR_COILS = 8'h0F;
   localparam logic [7:0] FC_WR_REGS = 8'h10;
   localparam logic [15:0] BITS_MAX = 16'h0080;
   localparam logic [15:0] WORDS_MAX = 16'h0040;
   localparam logic [15:0] COIL_ON = 16'hFF00;
   localparam logic [15:0] COIL_OFF = 16'h0000;
   localparam logic [16:0] ADDR_SPAN = 17'h0C350; // valid frame addresses below this
   // frame lengths in bytes, check code included except in the header length
   localparam logic [7:0] HDR_LEN = 8'h06;
   localparam logic [7:0] MIN_LEN_ASC = 8'h03;
   localparam logic [7:0] MIN_LEN_RTU = 8'h04;
   localparam logic [7:0] FIX_LEN_ASC = 8'h07;
   localparam logic [7:0] FIX_LEN_RTU = 8'h08;
   localparam logic [7:0] MULTI_EXTRA = 8'h02;    // byte count plus one data byte
   // characters and check codes
   localparam logic [7:0] CHR_COLON = 8'h3A;
   localparam logic [7:0] CHR_CR = 8'h0D;
   localparam logic [7:0] CHR_LF = 8'h0A;
   localparam logic [7:0] ASC_MASK = 8'h7F;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [3:0] TX_LEN_ASC = 4'hB;
   localparam logic [3:0] TX_LEN_RTU = 4'h5;

   typedef enum logic [0:0] {RX_HUNT = 1'b0, RX_BODY = 1'b1} mbs_rx_state_type;
   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_SEND = 2'b10} mbs_tx_state_type;

   // one byte through the reflected crc-16
   function automatic logic [15:0] mbs_crc_step(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

   // ascii hex digit to nibble, bit 4 set when the character is a hex digit
   function automatic logic [4:0] mbs_hex_val(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
      if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) return {1'b1, c[3:0] + 4'h9};
      return 5'h00;
   endfunction

   // nibble to upper-case ascii hex digit
   function automatic logic [7:0] mbs_hex_chr(input logic [3:0] n);
      return (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
   endfunction
endpackage

// file: verification/mbs_master_model.sv
// serial master model: sends ascii or rtu request frames, collects reply characters
`timescale 1ns/1ps
module mbs_master_model (
   input wire logic mclk,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   logic [7:0] got[$];
   logic [1:0] stall_ff = 2'h0;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
   end
   // ready one cycle in four, so reply characters must be held
   always @(posedge mclk) begin
      stall_ff <= stall_ff + 2'h1;
      if (tx_valid && tx_ready) got.push_back(tx_data);
   end
   assign tx_ready = (stall_ff == 2'h3);
   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
   endfunction
   // one character; the line shows a changed value once released
   task automatic put(input logic [7:0] c);
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_data <= c;
      @(posedge mclk);
      rx_valid <= 1'b0;
      rx_data <= ~c;
   endtask
   // colon, hex pairs high nibble first, lrc (optionally spoiled), cr lf
   task automatic frame(input logic [7:0] b[$], input logic [7:0] bad);
      logic [7:0] s;
      s = 8'h00;
      put(8'h3A);
      foreach (b[i]) begin
         put(hx(b[i][7:4]));
         put(hx(b[i][3:0]));
         s = s + b[i];
      end
      s = (~s + 8'h01) ^ bad;
      put(hx(s[7:4]));
      put(hx(s[3:0]));
      put(8'h0D);
      put(8'h0A);
   endtask
   // reflected crc-16 over one byte
   function automatic logic [15:0] cr(input logic [15:0] r, input logic [7:0] d);
      logic [15:0] x;
      x = r ^ {8'h00, d};
      for (int j = 0; j < 8; j++) x = x[0] ? ((x >> 1) ^ 16'hA001) : (x >> 1);
      return x;
   endfunction
   // idle gap, raw bytes, crc low byte first (optionally spoiled), idle gap
   task automatic rtu(input logic [7:0] b[$], input logic [7:0] bad);
      logic [15:0] s;
      s = 16'hFFFF;
      repeat (10) @(posedge mclk);
      foreach (b[i]) begin
         put(b[i]);
         s = cr(s, b[i]);
      end
      put(s[7:0] ^ bad);
      put(s[15:8]);
      repeat (8) @(posedge mclk);
   endtask
endmodule

// file: verification/tb_top.sv
// testbench: register access, ascii requests, exception replies and flags
`timescale 1ns/1ps
module tb_top;
   import mbs_pkg::*;
   logic mclk = 1'b0;
   logic rst_n, ascii_mode, scan_end, wr_en, rx_valid, tx_valid, tx_ready;
   logic err_f, done_f, req_ok, ok_seen, req_bcast;
   logic e_seen = 1'b0;
   logic [2:0] port_id, wr_sel, rd_sel;
   logic [7:0] cfg, rx_data, tx_data, req_fn;
   logic [15:0] wr_data, rd_data, err_code, req_addr, req_qty, v;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int d_run = 0;
   always #4 mclk = ~mclk;
   mbs_frame_handler #(.MS_CYCLES(4), .IDLE35_CYCLES(8)) i_mbs_frame_handler (.mclk(mclk),
      .rst_n(rst_n), .ascii_mode(ascii_mode), .port_id(port_id), .cfg_slave_number(cfg),
      .scan_end(scan_end), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .wr_en(wr_en), .wr_sel(wr_sel),
      .wr_data(wr_data), .rd_sel(rd_sel), .rd_data(rd_data), .comm_error_flag(err_f),
      .comm_done_flag(done_f), .comm_error_code(err_code), .req_ok(req_ok),
      .req_bcast(req_bcast), .req_fn(req_fn), .req_addr(req_addr), .req_qty(req_qty));
   mbs_master_model i_mbs_master_model (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
   // scan every 16 cycles; the cycle ceiling cuts a hang short
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      scan_end <= (cyc % 16 == 15);
      if (req_ok === 1'b1) ok_seen <= 1'b1;
      if (err_f === 1'b1) e_seen <= 1'b1;
      // length of the current completion pulse, kept until the edge after it falls
      d_run <= (done_f === 1'b1) ? d_run + 1 : 0;
      if (cyc == 30000) begin
         bad_count++;
         results();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] s, input logic [15:0] d);
      @(posedge mclk);
      wr_en <= 1'b1;
      wr_sel <= s;
      wr_data <= d;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] s, output logic [15:0] d);
      @(posedge mclk);
      rd_sel <= s;
      repeat (2) @(posedge mclk);
      #1 d = rd_data;
   endtask
   // send a frame; expected acceptance 0/1, 2 means not looked at
   task automatic req(input logic [7:0] b[$], input logic [7:0] bad, input int e);
      ok_seen <= 1'b0;
      if (ascii_mode) i_mbs_master_model.frame(b, bad);
      else i_mbs_master_model.rtu(b, bad);
      repeat (4) @(posedge mclk);
      if (e < 2) chk(ok_seen, e[0]);
   endtask
   // flag pulse lasts one scan; a replied error raises its error flag scans before completion
   task automatic flags(input logic e, input logic [7:0] code);
      int k;
      k = 0;
      while (done_f !== 1'b1 && k < 400) begin
         @(posedge mclk) #1 k++;
      end
      chk(err_code, code);
      k = 0;
      while (done_f === 1'b1 && k < 40) begin
         @(posedge mclk) #1 k++;
      end
      chk(e_seen, e);
      chk(d_run, 16);
      e_seen <= 1'b0;
   endtask
   // exception: request frame in, expected code; compares the whole ascii or rtu reply
   task automatic exc(input logic [7:0] b[$], input logic [7:0] code);
      logic [7:0] q[$];
      logic [7:0] r[$];
      logic [15:0] s;
      r = '{8'h08, b[1] | EXC_FLAG, code, 8'h00};
      r[3] = -(r[0] + r[1] + r[2]);
      s = CRC_INIT;
      for (int i = 0; i < 3; i++) s = i_mbs_master_model.cr(s, r[i]);
      q = '{8'h3A};
      foreach (r[i]) q = {q, i_mbs_master_model.hx(r[i][7:4]), i_mbs_master_model.hx(r[i][3:0])};
      q = {q, 8'h0D, 8'h0A};
      if (!ascii_mode) q = '{r[0], r[1], r[2], s[7:0], s[15:8]};
      i_mbs_master_model.got.delete();
      req(b, 8'h00, 2);
      flags(1'b1, code);
      chk(i_mbs_master_model.got.size(), q.size());
      foreach (q[i]) chk(i_mbs_master_model.got[i], q[i]);
   endtask
   task automatic results();
      if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      {rst_n, scan_end, wr_en, ok_seen} = 4'h0;
      {ascii_mode, port_id, cfg, wr_sel, wr_data, rd_sel} = {1'b1, 3'h2, 8'h05, 3'h7, 16'h0, 3'h0};
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      rd(SEL_TX_WAIT, v);
      chk(v, TX_WAIT_RST);
      wr(SEL_TX_WAIT, 16'h0001);
      wr(SEL_PORT2, 16'h0008);
      rd(SEL_PORT2, v);
      chk(v, 16'h0008);
      i_mbs_master_model.put(8'h3A);
      i_mbs_master_model.put(8'h31); // partial frame, restarted by the next colon
      req('{8'h08, 8'h03, 8'h06, 8'hAE, 8'h00, 8'h02}, 8'h00, 1);
      chk(req_fn, 8'h03);
      chk(req_addr, 16'h06AE);
      chk(req_qty, 16'h0002);
      req('{8'h09, 8'h03, 8'h06, 8'hAE, 8'h00, 8'h02}, 8'h00, 0);
      wr(SEL_PORT2, 16'h0100);
      req('{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 8'h00, 1);
      wr(SEL_PORT2, 16'h0008);
      req('{8'h08, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, 8'h00, 1);
      req('{8'h00, 8'h06, 8'h00, 8'h01, 8'h12, 8'h34}, 8'h00, 1);
      chk(req_bcast, 1'b1);
      exc('{8'h08, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, ERR_FUNC);
      exc('{8'h08, 8'h03, 8'hC3, 8'h50, 8'h00, 8'h01}, ERR_ADDR);
      exc('{8'h08, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00}, ERR_QTY);
      req('{8'h08, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 8'h01, 0);
      flags(1'b1, ERR_BCC);
      req('{8'h08}, 8'h00, 0);
      flags(1'b1, ERR_LEN);
      i_mbs_master_model.put(8'h3A);
      i_mbs_master_model.put(8'h47); // not a hex digit
      flags(1'b1, ERR_CHAR);
      rd(SEL_ERR_CODE, v);
      chk(v, {8'h00, ERR_CHAR});
      // second reset mid-run; rtu framing from here on
      @(posedge mclk);
      rst_n <= 1'b0;
      ascii_mode <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      i_mbs_master_model.put(8'h08); // no idle gap yet, so it must be ignored
      rd(SEL_PORT2, v);
      chk(v, 16'h0008);
      rd(SEL_TX_WAIT, v);
      chk(v, TX_WAIT_RST);
      wr(SEL_TX_WAIT, 16'h0002);
      req('{8'h08, 8'h03, 8'h06, 8'hAE, 8'h00, 8'h02}, 8'h00, 1);
      chk(req_bcast, 1'b0);
      exc('{8'h08, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00}, ERR_QTY);
      results();
   end
endmodule
